// file: hdl/ssm_cfg.svh
// Register map, field positions and reset values of the serial status/mode block
// Notes on behaviour
// RQ1: Flag bit 7 marks a pending request; writing 1 clears it.
// RQ2: Bit 7 stays set while any other event flag is still set.
// RQ3: Transmit overrun sets bit 6 until software writes 1 there.
// RQ4: Collision or mode fault sets bit 5; only writing 1 clears it.
// RQ5: Slave transaction abort sets bit 4; writing 1 clears it.
// RQ6: Receive overrun sets bit 3; writing 1 clears it.
// RQ7: Transmit underrun sets bit 2; it holds until 1 is written.
// RQ8: Bit 1 reads 1 while a transmission runs; writes are ignored.
// RQ9: In slave mode bit 0 reads 0 when selected, 1 when not.
// RQ10: Mode bit 7 picks right or left alignment of short transmit characters.
// RQ11: Mode field 5:2 gives bits per character; zero means sixteen.
// RQ12: Mode bit 1 set makes the select pin an output, else input.
// RQ13: The select direction setting counts only in master mode.
// RQ14: Output select pin follows mode bit 0; as input, bit 0 reads the pin.
// RQ15: Software keeps reserved bits 31:8 of both registers unchanged.
// RQ16: Software trigger bit in control also sets the pending flag.
// RQ17: Master enable bit 0 means slave, 1 means master.
// RQ18: Interrupt leaves the block only while interrupt enable is 1.
// RQ19: Any overrun, collision, abort or underrun event sets the pending flag.
`ifndef SSM_CFG_SVH
`define SSM_CFG_SVH
// Byte offsets on the register bus
`define SSM_CTRL_OFS    8'h04
`define SSM_FLAGS_OFS   8'h08
`define SSM_MODE_OFS    8'h0c
`define SSM_ISR_OFS     8'h20
`define SSM_IMASK_OFS   8'h24
// Event flag positions
`define SSM_FL_PEND     7
`define SSM_FL_TOVR     6
`define SSM_FL_COL      5
`define SSM_FL_ABT      4
`define SSM_FL_ROVR     3
`define SSM_FL_TUND     2
`define SSM_FL_BUSY     1
`define SSM_FL_SEL      0
`define SSM_EV_LO       2
`define SSM_EV_HI       6
// Mode fields
`define SSM_MD_ALIGN    7
`define SSM_MD_NB_HI    5
`define SSM_MD_NB_LO    2
`define SSM_MD_SSDIR    1
`define SSM_MD_SSVAL    0
// Control fields
`define SSM_CT_IRQE     7
`define SSM_CT_TRIG     6
`define SSM_CT_MMEN     1
`define SSM_CT_START    0
// Reset values
`define SSM_FLAGS_RST   8'h00
`define SSM_MODE_RST    8'h00
`define SSM_CTRL_RST    8'h00
`define SSM_IMASK_RST   8'h00
`endif

// file: hdl/ssm_pkg.sv
// Types and shared helpers of the serial status/mode block
package ssm_pkg;
   typedef logic [7:0]  ssm_byte_t;
   typedef logic [15:0] ssm_char_t;
   typedef logic [4:0]  ssm_cnt_t;

   // Bits per character from the 4-bit length field, zero meaning sixteen
   function automatic ssm_cnt_t ssm_char_len(input logic [3:0] field);
      ssm_cnt_t n;
      n = (field == 4'h0) ? 5'h10 : {1'b0, field};
      return n;
   endfunction : ssm_char_len
endpackage : ssm_pkg

// file: hdl/ssm_fmt_if.sv
// Carrier between the register core and the transmit formatter
`timescale 1ns/100ps
interface ssm_fmt_if;
   logic              align;
   logic [3:0]        len_field;
   ssm_pkg::ssm_char_t raw;
   logic              load;
   ssm_pkg::ssm_char_t chr;
   ssm_pkg::ssm_cnt_t  nbits;
   logic              valid;

   modport core (output align, output len_field, output raw, output load,
                 input chr, input nbits, input valid);
   modport fmt  (input align, input len_field, input raw, input load,
                 output chr, output nbits, output valid);
endinterface : ssm_fmt_if

// file: hdl/ssm_txfmt.sv
// Transmit character formatter: masks unused bits by alignment and length
`timescale 1ns/100ps
module ssm_txfmt (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Core side
   ssm_fmt_if.fmt   fif
);
   wire ssm_pkg::ssm_cnt_t  len_w  = ssm_pkg::ssm_char_len(fif.len_field);
   wire logic [4:0]         gap_w  = 5'h10 - len_w;
   wire ssm_pkg::ssm_char_t rmask_w = 16'hffff >> gap_w;
   wire ssm_pkg::ssm_char_t lmask_w = 16'hffff << gap_w;
   // Unused bits are forced to zero on the side away from the character
   wire ssm_pkg::ssm_char_t fmt_w  = fif.align ? (fif.raw & lmask_w)
                                               : (fif.raw & rmask_w);

   // Register the formatted character on each load
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         fif.chr   <= 16'h0000;
         fif.nbits <= 5'h10;
         fif.valid <= 1'b0;
      end else begin
         fif.valid <= fif.load;
         if (fif.load) begin
            fif.chr   <= fmt_w; // RQ10
            fif.nbits <= len_w; // RQ11
         end
      end
   end

   property fmt_zero_p;
      @(posedge mclk) disable iff (reset)
      fif.load |=> ((fif.chr & ~($past(fif.align) ? $past(lmask_w) : $past(rmask_w)))
                    == 16'h0000);
   endproperty
   fmt_zero_a: assert property (fmt_zero_p) // RQ10
      else $error("Unused character bits not zero");
endmodule : ssm_txfmt

// file: hdl/ssm_top.sv
// Status flags, mode register, select pin and interrupt logic of the serial port
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
`include "ssm_cfg.svh"
module ssm_top (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Events from the shifter and FIFOs, same clock
   input  wire logic        ev_tx_overrun,
   input  wire logic        ev_collision,
   input  wire logic        ev_rx_overrun,
   input  wire logic        ev_tx_underrun,
   input  wire logic        tx_busy_in,
   // Transmit word from the data path
   input  wire logic [15:0] tx_word,
   input  wire logic        tx_load,
   // Link pins
   input  wire logic        sck_in,
   input  wire logic        select_pin_in,
   output logic             select_pin_out,
   output logic             select_pin_oe,
   // Configuration and results to the shifter
   output logic             master_mode,
   output logic             port_start,
   output logic [15:0]      tx_char,
   output logic [4:0]       char_bits,
   output logic             tx_char_valid,
   // Interrupt
   output logic             irq
);
   // Registers
   ssm_pkg::ssm_byte_t flags_reg;
   ssm_pkg::ssm_byte_t mode_reg;
   ssm_pkg::ssm_byte_t ctrl_reg;
   ssm_pkg::ssm_byte_t isr_reg;
   ssm_pkg::ssm_byte_t imask_reg;
   ssm_pkg::ssm_byte_t rd_snap_reg;
   logic               rd_isr_reg;
   logic               txst_reg;
   logic               irq_reg;
   logic               ss_oe_reg;
   logic               ss_out_reg;
   logic [31:0]        prdata_reg;
   logic               pready_reg;
   logic               pslverr_reg;
   // Link synchronisers and filtered levels
   logic [2:0]         sck_sync_reg;
   logic [2:0]         sel_sync_reg;
   logic               sck_filt_reg;
   logic               sel_filt_reg;
   ssm_pkg::ssm_cnt_t  bit_cnt_reg;

   ssm_fmt_if fif ();

   ssm_txfmt u_fmt (
      .mclk  (mclk),
      .reset (reset),
      .fif   (fif)
   );

   // Transmit formatting follows the mode register
   assign fif.align     = mode_reg[`SSM_MD_ALIGN];
   assign fif.len_field = mode_reg[`SSM_MD_NB_HI:`SSM_MD_NB_LO];
   assign fif.raw       = tx_word;
   assign fif.load      = tx_load;

   // Bus phase decode
   wire logic setup_w  = psel & ~penable;
   wire logic done_w   = psel & penable & pready_reg;
   wire logic wr_done  = done_w & pwrite;
   wire logic hit_ctrl  = (paddr == `SSM_CTRL_OFS);
   wire logic hit_flags = (paddr == `SSM_FLAGS_OFS);
   wire logic hit_mode  = (paddr == `SSM_MODE_OFS);
   wire logic hit_isr   = (paddr == `SSM_ISR_OFS);
   wire logic hit_imask = (paddr == `SSM_IMASK_OFS);
   wire logic hit_any   = hit_ctrl | hit_flags | hit_mode | hit_isr | hit_imask;
   wire logic wr_ctrl   = wr_done & hit_ctrl;
   wire logic wr_flags  = wr_done & hit_flags;
   wire logic wr_mode   = wr_done & hit_mode;
   wire logic wr_imask  = wr_done & hit_imask;

   // Operating role and select pin direction
   wire logic is_master = ctrl_reg[`SSM_CT_MMEN]; // RQ17
   // Direction bit is ignored as slave, so the pin stays an input there
   wire logic ss_drive  = is_master & mode_reg[`SSM_MD_SSDIR]; // RQ12 RQ13
   wire logic ssv_bit   = mode_reg[`SSM_MD_SSVAL];

   // Link edges from the filtered levels
   logic sck_prev_reg;
   logic sel_prev_reg;
   wire logic sck_rise  = sck_filt_reg & ~sck_prev_reg;
   wire logic sel_rise  = sel_filt_reg & ~sel_prev_reg;
   wire logic selected  = ~sel_filt_reg;
   wire ssm_pkg::ssm_cnt_t len_w =
      ssm_pkg::ssm_char_len(mode_reg[`SSM_MD_NB_HI:`SSM_MD_NB_LO]);
   wire logic slave_busy = ~is_master & selected & (bit_cnt_reg != 5'h00);
   // Deselect in the middle of a character aborts the slave transaction
   wire logic ev_abort   = ~is_master & sel_rise & (bit_cnt_reg != 5'h00);
   // Another master pulling select low while we drive the bus is a mode fault
   wire logic ev_modef   = is_master & ~ss_drive & ctrl_reg[`SSM_CT_START] &
                           ~sel_filt_reg & sel_prev_reg;
   wire ssm_pkg::ssm_cnt_t cnt_next =
      (~is_master & selected & sck_rise)
         ? ((bit_cnt_reg + 5'h01 == len_w) ? 5'h00 : 5'(bit_cnt_reg + 5'h01))
         : (selected ? bit_cnt_reg : 5'h00);

   // Event vector in flag layout
   wire ssm_pkg::ssm_byte_t ev_w = {1'b0,
                                    ev_tx_overrun,
                                    ev_collision | ev_modef,
                                    ev_abort,
                                    ev_rx_overrun,
                                    ev_tx_underrun,
                                    2'b00};
   wire logic [4:0] ev_bits  = ev_w[`SSM_EV_HI:`SSM_EV_LO];
   wire logic [4:0] w1c_bits = wr_flags ? pwdata[`SSM_EV_HI:`SSM_EV_LO] : 5'h00;
   // Set wins over a clear in the same cycle
   wire logic [4:0] evf_next = ev_bits | (flags_reg[`SSM_EV_HI:`SSM_EV_LO] & ~w1c_bits);
   wire logic trig_w   = wr_ctrl & pwdata[`SSM_CT_TRIG];
   wire logic pend_set = (|ev_bits) | trig_w; // RQ16 RQ19
   wire logic pend_clr = wr_flags & pwdata[`SSM_FL_PEND] & ~(|evf_next); // RQ1 RQ2
   wire logic pend_next = pend_set | (flags_reg[`SSM_FL_PEND] & ~pend_clr);
   // Trigger bit drops once the pending flag has been cleared
   wire logic trig_keep = ctrl_reg[`SSM_CT_TRIG] & pend_next;

   // Read view of each register
   wire logic sel_view  = is_master ? 1'b1 : sel_filt_reg; // RQ9
   wire logic ssv_view  = ss_drive ? mode_reg[`SSM_MD_SSVAL] : sel_filt_reg; // RQ14
   wire ssm_pkg::ssm_byte_t flags_view = {flags_reg[7:2], txst_reg, sel_view}; // RQ8
   wire ssm_pkg::ssm_byte_t mode_view  = {mode_reg[7:1], ssv_view};
   wire ssm_pkg::ssm_byte_t rd_byte =
      hit_ctrl  ? ctrl_reg  :
      hit_flags ? flags_view :
      hit_mode  ? mode_view :
      hit_isr   ? isr_reg   :
      hit_imask ? imask_reg : 8'h00;

   // Bus answer: data latched at setup, ready in the access cycle
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else begin
         pready_reg  <= setup_w;
         pslverr_reg <= setup_w & ~hit_any;
         if (setup_w) begin
            prdata_reg <= {24'h00_0000, rd_byte};
         end
      end
   end

   // Snapshot of the status read so only bits seen are cleared
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rd_snap_reg <= 8'h00;
         rd_isr_reg  <= 1'b0;
      end else begin
         rd_isr_reg <= setup_w & hit_isr & ~pwrite;
         if (setup_w) begin
            rd_snap_reg <= isr_reg;
         end
      end
   end

   // Control and mode registers; reserved bits are not stored
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ctrl_reg <= `SSM_CTRL_RST;
         mode_reg <= `SSM_MODE_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= pwdata[7:0];
         end else begin
            ctrl_reg[`SSM_CT_TRIG] <= trig_keep;
         end
         if (wr_mode) begin
            mode_reg <= {pwdata[7], 1'b0, pwdata[5:0]}; // RQ11 RQ14
         end
      end
   end

   // Event flags: sticky, write one to clear
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         flags_reg <= `SSM_FLAGS_RST;
      end else begin
         flags_reg[`SSM_FL_PEND] <= pend_next; // RQ1 RQ2
         flags_reg[`SSM_EV_HI:`SSM_EV_LO] <= evf_next; // RQ3 RQ4 RQ5 RQ6 RQ7
      end
   end

   // Interrupt status clears on read, mask gates it, enable gates the output
   wire ssm_pkg::ssm_byte_t isr_set = ev_w | {trig_w, 7'h00};
   wire ssm_pkg::ssm_byte_t isr_clr = (rd_isr_reg & done_w) ? rd_snap_reg : 8'h00;
   wire logic irq_en   = ctrl_reg[`SSM_CT_IRQE];
   wire logic irq_next = irq_en & (|(isr_reg & imask_reg)); // RQ18
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         isr_reg   <= 8'h00;
         imask_reg <= `SSM_IMASK_RST;
         irq_reg   <= 1'b0;
      end else begin
         isr_reg <= isr_set | (isr_reg & ~isr_clr);
         irq_reg <= irq_next;
         if (wr_imask) begin
            imask_reg <= pwdata[7:0];
         end
      end
   end

   // Three-stage synchronisers; a level counts once stages two and three agree
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         sck_sync_reg <= 3'h0;
         sel_sync_reg <= 3'h7;
         sck_filt_reg <= 1'b0;
         sel_filt_reg <= 1'b1;
      end else begin
         sck_sync_reg <= {sck_sync_reg[1:0], sck_in};
         sel_sync_reg <= {sel_sync_reg[1:0], select_pin_in};
         if (sck_sync_reg[1] == sck_sync_reg[2]) begin
            sck_filt_reg <= sck_sync_reg[2];
         end
         if (sel_sync_reg[1] == sel_sync_reg[2]) begin
            sel_filt_reg <= sel_sync_reg[2];
         end
      end
   end

   // Edge history and slave bit counter
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         sck_prev_reg <= 1'b0;
         sel_prev_reg <= 1'b1;
         bit_cnt_reg  <= 5'h00;
      end else begin
         sck_prev_reg <= sck_filt_reg;
         sel_prev_reg <= sel_filt_reg;
         bit_cnt_reg  <= cnt_next; // RQ11
      end
   end

   // Busy state and select pin drive
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         txst_reg   <= 1'b0;
         ss_oe_reg  <= 1'b0;
         ss_out_reg <= 1'b1;
      end else begin
         txst_reg   <= tx_busy_in | slave_busy; // RQ8
         ss_oe_reg  <= ss_drive; // RQ12 RQ13
         ss_out_reg <= mode_reg[`SSM_MD_SSVAL]; // RQ14
      end
   end

   // Outputs
   assign prdata         = prdata_reg;
   assign pready         = pready_reg;
   assign pslverr        = pslverr_reg;
   assign select_pin_out = ss_out_reg;
   assign select_pin_oe  = ss_oe_reg;
   assign master_mode    = ctrl_reg[`SSM_CT_MMEN];
   assign port_start     = ctrl_reg[`SSM_CT_START];
   assign tx_char        = fif.chr;
   assign char_bits      = fif.nbits;
   assign tx_char_valid  = fif.valid;
   assign irq            = irq_reg;

   // Checks
   sequence flag_w1c_s(int b);
      wr_flags ##0 pwdata[b];
   endsequence

   sequence mid_char_deselect_s;
      (~is_master & selected & (bit_cnt_reg != 5'h00)) ##1 (sel_rise & (bit_cnt_reg != 5'h00));
   endsequence

   pend_set_a: assert property (@(posedge mclk) disable iff (reset) // RQ19
      (|ev_bits) |=> flags_reg[`SSM_FL_PEND])
      else $error("Event did not raise pending flag");

   pend_hold_a: assert property (@(posedge mclk) disable iff (reset) // RQ2
      (flags_reg[`SSM_FL_PEND] & (|evf_next)) |=> flags_reg[`SSM_FL_PEND])
      else $error("Pending flag cleared while events remain");

   pend_clr_a: assert property (@(posedge mclk) disable iff (reset) // RQ1
      (flag_w1c_s(`SSM_FL_PEND) ##0 ~(|evf_next) ##0 ~pend_set)
      |=> ~flags_reg[`SSM_FL_PEND])
      else $error("Pending flag not cleared by write one");

   tovr_set_a: assert property (@(posedge mclk) disable iff (reset) // RQ3
      ev_tx_overrun |=> flags_reg[`SSM_FL_TOVR])
      else $error("Transmit overrun flag not set");

   rovr_hold_a: assert property (@(posedge mclk) disable iff (reset) // RQ6
      (flags_reg[`SSM_FL_ROVR] & ~wr_flags) |=> flags_reg[`SSM_FL_ROVR])
      else $error("Receive overrun flag lost without a clear");

   tund_clr_a: assert property (@(posedge mclk) disable iff (reset) // RQ7
      (flag_w1c_s(`SSM_FL_TUND) ##0 ~ev_tx_underrun) |=> ~flags_reg[`SSM_FL_TUND])
      else $error("Underrun flag not cleared");

   abort_a: assert property (@(posedge mclk) disable iff (reset) // RQ5
      mid_char_deselect_s |=> flags_reg[`SSM_FL_ABT])
      else $error("Slave abort not flagged");

   busy_follow_a: assert property (@(posedge mclk) disable iff (reset) // RQ8
      tx_busy_in |=> txst_reg)
      else $error("Busy bit not shown during transmission");

   ss_dir_a: assert property (@(posedge mclk) disable iff (reset) // RQ13
      1'b1 |=> (select_pin_oe == $past(ss_drive)))
      else $error("Select pin direction wrong");

   ss_val_a: assert property (@(posedge mclk) disable iff (reset) // RQ14
      ss_drive |=> (select_pin_out == $past(ssv_bit)))
      else $error("Select pin not driven to written value");

   irq_gate_a: assert property (@(posedge mclk) disable iff (reset) // RQ18
      irq |-> $past(irq_en))
      else $error("Interrupt forwarded while disabled");

   // Mode fault from the select pin must land in the collision flag too
   col_set_a: assert property (@(posedge mclk) disable iff (reset) // RQ4
      (ev_collision | ev_modef) |=> flags_reg[`SSM_FL_COL])
      else $error("Collision flag not set");

   abt_hold_a: assert property (@(posedge mclk) disable iff (reset) // RQ5
      (flags_reg[`SSM_FL_ABT] & ~wr_flags) |=> flags_reg[`SSM_FL_ABT])
      else $error("Abort flag lost without a clear");

   trig_pend_a: assert property (@(posedge mclk) disable iff (reset) // RQ16
      trig_w |=> flags_reg[`SSM_FL_PEND])
      else $error("Software trigger did not raise pending flag");

   slave_in_a: assert property (@(posedge mclk) disable iff (reset) // RQ13
      ~is_master |=> ~select_pin_oe)
      else $error("Select pin driven in slave mode");
endmodule : ssm_top

// file: verif/ssm_spi_peer.sv
// External SPI master model that drives the link clock and the select line
`timescale 1ns/100ps
module ssm_spi_peer (
   // Link pins
   output logic sck,
   output logic sel_n_drv,
   output logic sel_n_en
);
   // Idle: clock low and still, select released to the pull-up
   initial begin
      sck = 1'b0;
      sel_n_drv = 1'b1;
      sel_n_en = 1'b0;
   end

   // One frame of n clocks; the clock stands still outside frames
   task automatic frame(input int n);
      // Offset keeps every pin change away from the sampling clock edge
      #10;
      sel_n_en = 1'b1;
      sel_n_drv = 1'b0;
      #320;
      repeat (n) begin
         #160 sck = 1'b1;
         #160 sck = 1'b0;
      end
      #320;
      sel_n_drv = 1'b1;
      #160;
      sel_n_en = 1'b0;
   endtask : frame

   // Hold select low, or release it to the pull-up
   task automatic pull(input logic low);
      #10;
      sel_n_en = low;
      sel_n_drv = ~low;
   endtask : pull
endmodule : ssm_spi_peer

// file: verif/ssm_top_test.sv
// Self-checking bench of the serial status/mode block
`timescale 1ns/100ps
module ssm_top_test;
   logic        mclk = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, er;
   logic [3:0]  ev = 4'h0;
   logic        tx_busy_in = 1'b0, tx_load = 1'b0;
   logic [15:0] tx_word = 16'h0000, tx_char, w;
   logic        sck, sel_n_drv, sel_n_en, pin;
   logic        select_pin_out, select_pin_oe, master_mode, port_start, tx_char_valid, irq;
   logic [4:0]  char_bits;
   logic [3:0]  f;
   logic        al;
   int          n_fail = 0, comparisons = 0, k, seed = 32'ha469;
   int          pos[4] = '{6, 5, 3, 2};

   always #20 mclk = ~mclk;
   // Wire level of the select pin; a pull-up holds it high when nobody drives
   assign pin = select_pin_oe ? select_pin_out : (sel_n_en ? sel_n_drv : 1'b1);

   ssm_top DUT (
      .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ev_tx_overrun(ev[0]), .ev_collision(ev[1]), .ev_rx_overrun(ev[2]),
      .ev_tx_underrun(ev[3]), .tx_busy_in(tx_busy_in), .tx_word(tx_word), .tx_load(tx_load),
      .sck_in(sck), .select_pin_in(pin), .select_pin_out(select_pin_out),
      .select_pin_oe(select_pin_oe), .master_mode(master_mode), .port_start(port_start),
      .tx_char(tx_char), .char_bits(char_bits), .tx_char_valid(tx_char_valid), .irq(irq));

   ssm_spi_peer peer (.sck(sck), .sel_n_drv(sel_n_drv), .sel_n_en(sel_n_en));

   task automatic tally_and_finish();
      if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // One APB transfer; the request is held until pready is sampled high
   task automatic apb(input logic wr_en, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] r, output logic e);
      int i;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr_en;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge mclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge mclk);
         i++;
      end while (pready !== 1'b1 && i < 16);
      if (pready !== 1'b1) begin
         chk(32'h0, 32'h1);
         tally_and_finish();
      end else begin
         r = prdata;
         e = pslverr;
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d, rd, er);
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00, rd, er);
      chk(rd, {24'h000000, exp});
   endtask : rdchk

   task automatic pulse(input int i);
      @(posedge mclk);
      ev[i] <= 1'b1;
      @(posedge mclk);
      ev <= 4'h0;
   endtask : pulse

   // Expected formatted character: unused bits zero on the side given by alignment
   function automatic logic [15:0] fmt_exp(input logic [15:0] wd, input logic [3:0] fl,
                                           input logic a);
      int n;
      n = (fl == 4'h0) ? 16 : int'(fl);
      return a ? 16'(wd & ~((16'h1 << (16 - n)) - 16'h1)) : 16'(wd & ((17'h1 << n) - 17'h1));
   endfunction : fmt_exp

   // Expected flag byte in slave mode, not selected, after one burst of events
   function automatic logic [7:0] flags_exp(input logic [3:0] e, input logic b);
      return {|e, e[0], e[1], 1'b0, e[2], e[3], b, 1'b1};
   endfunction : flags_exp

   // Watchdog cuts a hang short
   initial begin
      repeat (100000) @(posedge mclk);
      chk(32'h0, 32'h1);
      tally_and_finish();
   end

   initial begin
      repeat (16) @(posedge mclk);
      reset <= 1'b0;
      // Reset values; select idles high and mode bit 0 shows the pin
      rdchk(8'h08, 8'h01);
      rdchk(8'h0c, 8'h01);
      apb(1'b0, 8'h10, 8'h00, rd, er);
      chk({31'h0, er}, 32'h1);
      // Each event sets its flag and the pending flag; pending holds while it is set
      for (k = 0; k < 4; k++) begin
         pulse(k);
         rdchk(8'h08, 8'h81 | (8'h01 << pos[k]));
         wr(8'h08, 8'h80);
         rdchk(8'h08, 8'h81 | (8'h01 << pos[k]));
         wr(8'h08, 8'hff);
         rdchk(8'h08, 8'h01);
      end
      // Busy bit follows the shifter and ignores writes
      tx_busy_in <= 1'b1;
      wr(8'h08, 8'h02);
      rdchk(8'h08, 8'h03);
      tx_busy_in <= 1'b0;
      // Software trigger sets pending; clearing pending drops the trigger
      wr(8'h04, 8'h40);
      rdchk(8'h08, 8'h81);
      wr(8'h08, 8'h80);
      rdchk(8'h08, 8'h01);
      // Interrupt raised, cleared by reading status, then masked
      rdchk(8'h20, 8'hec);
      wr(8'h04, 8'h80);
      wr(8'h24, 8'h08);
      pulse(2);
      @(posedge mclk);
      #1 chk({31'h0, irq}, 32'h1);
      rdchk(8'h20, 8'h08);
      repeat (2) @(posedge mclk);
      #1 chk({31'h0, irq}, 32'h0);
      wr(8'h24, 8'h00);
      pulse(3);
      repeat (3) @(posedge mclk);
      #1 chk({31'h0, irq}, 32'h0);
      wr(8'h04, 8'h00);
      pulse(1);
      repeat (3) @(posedge mclk);
      #1 chk({31'h0, irq}, 32'h0);
      rdchk(8'h20, 8'h24);
      wr(8'h08, 8'hff);
      // Random event bursts and busy level; flags collect exactly what was pulsed
      for (k = 0; k < 8; k++) begin
         f = 4'($random(seed));
         al = 1'($random(seed));
         @(posedge mclk);
         ev <= f;
         tx_busy_in <= al;
         @(posedge mclk);
         ev <= 4'h0;
         rdchk(8'h08, flags_exp(f, al));
         wr(8'h08, 8'hff);
      end
      tx_busy_in <= 1'b0;
      // Mode bit 6 reads zero
      wr(8'h0c, 8'hff);
      rdchk(8'h0c, 8'hbf);
      // Formatter: zero-length field and both alignments first, then random
      for (k = 0; k < 24; k++) begin
         f = (k < 2) ? 4'h0 : 4'($random(seed));
         al = (k < 2) ? k[0] : 1'($random(seed));
         w = 16'($random(seed));
         wr(8'h0c, {al, 1'b0, f, 2'b00});
         @(posedge mclk);
         tx_word <= w;
         tx_load <= 1'b1;
         @(posedge mclk);
         tx_load <= 1'b0;
         #1 chk({31'h0, tx_char_valid}, 32'h1);
         chk({16'h0, tx_char}, {16'h0, fmt_exp(w, f, al)});
         chk({27'h0, char_bits}, (f == 4'h0) ? 32'd16 : {28'h0, f});
      end
      // Master with select as output drives the written value
      wr(8'h04, 8'h02);
      wr(8'h0c, 8'h02);
      repeat (2) @(posedge mclk);
      #1 chk({30'h0, select_pin_oe, pin}, 32'h2);
      wr(8'h0c, 8'h03);
      rdchk(8'h0c, 8'h03);
      chk({31'h0, pin}, 32'h1);
      wr(8'h04, 8'h00);
      repeat (2) @(posedge mclk);
      #1 chk({31'h0, select_pin_oe}, 32'h0);
      // Select as input: mode bit 0 reads the pin
      wr(8'h0c, 8'h20);
      peer.pull(1'b1);
      repeat (6) @(posedge mclk);
      rdchk(8'h0c, 8'h20);
      peer.pull(1'b0);
      // Slave frame of full length: busy and selected meanwhile, no abort
      wr(8'h04, 8'h01);
      fork
         peer.frame(8);
         begin
            repeat (30) @(posedge mclk);
            rdchk(8'h08, 8'h02);
         end
      join
      repeat (6) @(posedge mclk);
      rdchk(8'h08, 8'h01);
      // Short frame is an abort
      peer.frame(3);
      repeat (6) @(posedge mclk);
      rdchk(8'h08, 8'h91);
      wr(8'h08, 8'hff);
      // Started master with select input sees select pulled low: collision
      wr(8'h04, 8'h03);
      peer.pull(1'b1);
      repeat (8) @(posedge mclk);
      chk({30'h0, master_mode, port_start}, 32'h3);
      rdchk(8'h08, 8'ha1);
      peer.pull(1'b0);
      wr(8'h04, 8'h00);
      tally_and_finish();
   end
endmodule : ssm_top_test
